// >>> design/tmr2_pkg.sv
package tmr2_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] ADDR_CTRL = 8'hc8;
  localparam logic [7:0] ADDR_MODE = 8'hc9;
  localparam logic [7:0] ADDR_CNT_LO = 8'hcc;
  localparam logic [7:0] ADDR_CNT_HI = 8'hcd;
  localparam logic [7:0] ADDR_CAP_LO = 8'hca;
  localparam logic [7:0] ADDR_CAP_HI = 8'hcb;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] COUNT_TOP = 16'hffff;
  localparam logic [7:0] BYTE_TOP = 8'hff;
  // Prescaler for the internal count rate
  localparam int PRESCALE_DIV = 12;
  localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_DIV - 1);
  localparam logic [3:0] PRESCALE_ZERO = 4'h0;

  // Control register field layout, bit 7 down to bit 0
  typedef struct packed {
    logic overflowFlag;
    logic externalFlag;
    logic receiveClockSelect;
    logic transmitClockSelect;
    logic externalEnable;
    logic runBit;
    logic countSourceSelect;
    logic captureReloadSelect;
  } tmr2_ctrl_s;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmr2_bus_s;

  // Whole block state
  typedef struct packed {
    tmr2_ctrl_s ctrl;
    logic upDownEnable;
    logic [7:0] countLow;
    logic [7:0] countHigh;
    logic [7:0] capLow;
    logic [7:0] capHigh;
    logic [3:0] prescale;
    logic [1:0] countPinSync;
    logic countPinLast;
    logic [1:0] trigPinSync;
    logic trigPinLast;
    logic [7:0] rdata;
  } tmr2_state_s;
endpackage : tmr2_pkg

// >>> design/tmr2_timer.sv
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
// Functional notes
// - Sixteen-bit count in low and high bytes, low carry bumps high.
// - Source select: clear counts clock over twelve, set counts count pin.
// - Counter mode advances on each sampled falling edge of count pin.
// - Low byte advances only while run bit set; clearing stops timer.
// - Either serial clock select forces auto-reload, capture select ignored.
// - Reload mode reloads on overflow, and on trigger fall if enabled.
// - Capture mode with external enable captures on trigger fall.
// - External enable gates trigger events, only when not clocking serial port.
// - Up/down enable in reload mode uses trigger level for direction.
// - Up overflow at all-ones sets flag, requests interrupt, loads reload pair in reload mode, zero in capture mode.
// - Down underflow at reload value sets flag and loads all-ones.
// - Up/down mode toggles external flag per wrap, never interrupting.
// - Overflow flag set only with both serial selects clear; software clears.
// - Trigger capture or reload sets external flag; software clears it.
// - Receive select routes this overflow or timer one overflow to receive.
// - Transmit select routes this overflow or timer one overflow to transmit.
module tmr2_timer
  import tmr2_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] busAddr,
  input wire logic [7:0] busWdata,
  input wire logic busWr,
  input wire logic busRd,
  output logic [7:0] busRdata,
  input wire logic externalCountPin,
  input wire logic externalTriggerPin,
  input wire logic timerOneOverflow,
  output logic receiveClockTick,
  output logic transmitClockTick,
  output logic timerIrq
);

  tmr2_state_s stateReg;
  tmr2_state_s stateNext;
  tmr2_bus_s bus;
  logic countTick;
  logic trigFall;
  logic serialClocking;
  logic reloadMode;
  logic upDownMode;
  logic countDown;
  logic wrapEvent;
  logic [15:0] count;
  logic [15:0] capture;
  logic [15:0] countNext;

  // Byte select helper used by writes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  assign bus = '{addr: busAddr, wdata: busWdata, wr: busWr, rd: busRd};
  assign count = {stateReg.countHigh, stateReg.countLow};
  assign capture = {stateReg.capHigh, stateReg.capLow};
  assign serialClocking = stateReg.ctrl.receiveClockSelect | stateReg.ctrl.transmitClockSelect;
  assign reloadMode = serialClocking | ~stateReg.ctrl.captureReloadSelect;
  assign upDownMode = reloadMode & stateReg.upDownEnable;
  assign countDown = upDownMode & ~stateReg.trigPinSync[1];
  assign trigFall = stateReg.trigPinLast & ~stateReg.trigPinSync[1];

  // Count enable from prescaler or pin edge
  always_comb begin
    if (stateReg.ctrl.countSourceSelect) begin
      countTick = stateReg.countPinLast & ~stateReg.countPinSync[1];
    end else begin
      countTick = stateReg.prescale == PRESCALE_LAST;
    end
    countTick = countTick & stateReg.ctrl.runBit;
  end

  // Wrap detection and next count
  always_comb begin
    wrapEvent = 1'b0;
    countNext = count;
    if (countTick) begin
      if (countDown) begin
        if (count == capture) begin
          wrapEvent = 1'b1;
          countNext = COUNT_TOP;
        end else begin
          countNext = count - 16'h0001;
        end
      end else if (count == COUNT_TOP) begin
        wrapEvent = 1'b1;
        countNext = reloadMode ? capture : 16'h0000;
      end else begin
        countNext = count + 16'h0001;
      end
    end
  end

  assign receiveClockTick = stateReg.ctrl.receiveClockSelect ? wrapEvent : timerOneOverflow;
  assign transmitClockTick = stateReg.ctrl.transmitClockSelect ? wrapEvent : timerOneOverflow;
  // external flag silent in up/down mode
  assign timerIrq = stateReg.ctrl.overflowFlag | (stateReg.ctrl.externalFlag & ~upDownMode);
  assign busRdata = stateReg.rdata;

  // Next state
  always_comb begin
    stateNext = stateReg;
    stateNext.countPinSync = {stateReg.countPinSync[0], externalCountPin};
    stateNext.countPinLast = stateReg.countPinSync[1];
    stateNext.trigPinSync = {stateReg.trigPinSync[0], externalTriggerPin};
    stateNext.trigPinLast = stateReg.trigPinSync[1];
    if (stateReg.prescale == PRESCALE_LAST) begin
      stateNext.prescale = PRESCALE_ZERO;
    end else begin
      stateNext.prescale = stateReg.prescale + 4'h1;
    end
    // Software writes first, hardware events override flags
    if (bus.wr) begin
      if (hit(bus.addr, ADDR_CTRL)) begin
        stateNext.ctrl = tmr2_ctrl_s'(bus.wdata);
      end
      if (hit(bus.addr, ADDR_MODE)) begin
        stateNext.upDownEnable = bus.wdata[0];
      end
      // software writes to capture bytes
      if (hit(bus.addr, ADDR_CAP_LO)) begin
        stateNext.capLow = bus.wdata;
      end
      if (hit(bus.addr, ADDR_CAP_HI)) begin
        stateNext.capHigh = bus.wdata;
      end
    end
    {stateNext.countHigh, stateNext.countLow} = countNext;
    if (bus.wr && hit(bus.addr, ADDR_CNT_LO)) begin
      stateNext.countLow = bus.wdata;
    end
    if (bus.wr && hit(bus.addr, ADDR_CNT_HI)) begin
      stateNext.countHigh = bus.wdata;
    end
    // overflow flag only when not serial clocking
    if (wrapEvent && !serialClocking) begin
      stateNext.ctrl.overflowFlag = 1'b1;
    end
    if (wrapEvent && upDownMode) begin
      stateNext.ctrl.externalFlag = ~stateReg.ctrl.externalFlag;
    end
    if (trigFall && stateReg.ctrl.externalEnable && !serialClocking) begin
      stateNext.ctrl.externalFlag = 1'b1;
      if (reloadMode) begin
        {stateNext.countHigh, stateNext.countLow} = capture;
      end else begin
        stateNext.capHigh = stateReg.countHigh;
        stateNext.capLow = stateReg.countLow;
      end
    end
    // Read data valid one cycle after strobe
    stateNext.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        ADDR_CTRL: stateNext.rdata = stateReg.ctrl;
        ADDR_MODE: stateNext.rdata = {7'h00, stateReg.upDownEnable};
        ADDR_CNT_LO: stateNext.rdata = stateReg.countLow;
        ADDR_CNT_HI: stateNext.rdata = stateReg.countHigh;
        ADDR_CAP_LO: stateNext.rdata = stateReg.capLow;
        ADDR_CAP_HI: stateNext.rdata = stateReg.capHigh;
        default: stateNext.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

  a_up_overflow: assert property (@(posedge clock) disable iff (rst)
    (countTick && !countDown && count == COUNT_TOP && reloadMode && !bus.wr)
    |=> ({stateReg.countHigh, stateReg.countLow} == $past(capture)))
    else $error("up overflow did not reload");
  a_down_underflow: assert property (@(posedge clock) disable iff (rst)
    (countTick && countDown && count == capture && !bus.wr && !trigFall)
    |=> count == COUNT_TOP && (stateReg.ctrl.overflowFlag || $past(serialClocking)))
    else $error("underflow did not load all ones");
  a_run_gate: assert property (@(posedge clock) disable iff (rst)
    (!stateReg.ctrl.runBit && !bus.wr && !trigFall) |=> $stable(count))
    else $error("count moved while stopped");
  // flag stays clear while serial clocking
  a_flag_serial: assert property (@(posedge clock) disable iff (rst)
    (serialClocking && !stateReg.ctrl.overflowFlag && !bus.wr) |=> !stateReg.ctrl.overflowFlag)
    else $error("overflow flag set while serial clocking");
  a_ext_toggle: assert property (@(posedge clock) disable iff (rst)
    (wrapEvent && upDownMode && !bus.wr && !trigFall)
    |=> stateReg.ctrl.externalFlag != $past(stateReg.ctrl.externalFlag))
    else $error("external flag did not toggle");
  a_capture_copy: assert property (@(posedge clock) disable iff (rst)
    (trigFall && stateReg.ctrl.externalEnable && !reloadMode && !bus.wr)
    |=> capture == $past(count) && stateReg.ctrl.externalFlag)
    else $error("capture did not copy count");
  a_trig_ignored: assert property (@(posedge clock) disable iff (rst)
    (trigFall && !stateReg.ctrl.externalEnable && !bus.wr && !wrapEvent)
    |=> $stable(capture) && $stable(stateReg.ctrl.externalFlag))
    else $error("trigger not ignored");
  // prescaled timer counts once per twelve cycles
  a_prescale: assert property (@(posedge clock) disable iff (rst)
    (countTick && !stateReg.ctrl.countSourceSelect) |=> !countTick [*8])
    else $error("prescaled count too fast");
  a_rx_route: assert property (@(posedge clock) disable iff (rst)
    !stateReg.ctrl.receiveClockSelect |-> receiveClockTick == timerOneOverflow)
    else $error("receive clock misrouted");
  a_rx_wrap: assert property (@(posedge clock) disable iff (rst)
    stateReg.ctrl.receiveClockSelect |-> receiveClockTick == wrapEvent)
    else $error("receive clock not own wrap");
  a_tx_route: assert property (@(posedge clock) disable iff (rst)
    !stateReg.ctrl.transmitClockSelect |-> transmitClockTick == timerOneOverflow)
    else $error("transmit clock misrouted");
  a_tx_wrap: assert property (@(posedge clock) disable iff (rst)
    stateReg.ctrl.transmitClockSelect |-> transmitClockTick == wrapEvent)
    else $error("transmit clock not own wrap");

  // Trigger fall that reloads the count
  sequence s_trig_reload;
    trigFall && stateReg.ctrl.externalEnable && reloadMode && !serialClocking && !bus.wr;
  endsequence
  a_trig_reload: assert property (@(posedge clock) disable iff (rst)
    s_trig_reload |=> count == $past(capture) && stateReg.ctrl.externalFlag)
    else $error("trigger did not reload");

  // Plain count step without trigger fall or write
  sequence s_plain_step;
    countTick && !bus.wr && !trigFall;
  endsequence
  // up step carries into high byte
  a_up_step: assert property (@(posedge clock) disable iff (rst)
    s_plain_step ##0 (!countDown && count != COUNT_TOP)
    |=> count == $past(count) + 16'h0001)
    else $error("up step wrong");
  a_down_step: assert property (@(posedge clock) disable iff (rst)
    s_plain_step ##0 (countDown && count != capture)
    |=> count == $past(count) - 16'h0001)
    else $error("down step wrong");
  // no interrupt from external flag in up/down mode
  a_updown_quiet: assert property (@(posedge clock) disable iff (rst)
    (upDownMode && !stateReg.ctrl.overflowFlag) |-> !timerIrq)
    else $error("external flag interrupted in up/down mode");
  a_ovf_irq: assert property (@(posedge clock) disable iff (rst)
    stateReg.ctrl.overflowFlag |-> timerIrq)
    else $error("overflow flag without interrupt");
  // overflow flag held until software clears
  a_ovf_sticky: assert property (@(posedge clock) disable iff (rst)
    (stateReg.ctrl.overflowFlag && !bus.wr) |=> stateReg.ctrl.overflowFlag)
    else $error("overflow flag cleared by hardware");
  // external flag held until software clears or an up/down mode wrap toggles it
  a_ext_sticky: assert property (@(posedge clock) disable iff (rst)
    (stateReg.ctrl.externalFlag && !bus.wr && !(wrapEvent && upDownMode))
    |=> stateReg.ctrl.externalFlag)
    else $error("external flag cleared by hardware");
  a_read_ctrl: assert property (@(posedge clock) disable iff (rst)
    (bus.rd && bus.addr == ADDR_CTRL) |=> busRdata == $past(stateReg.ctrl))
    else $error("control read data wrong");
  a_read_idle: assert property (@(posedge clock) disable iff (rst)
    !bus.rd |=> busRdata == 8'h00)
    else $error("read data without strobe");
  a_count_write: assert property (@(posedge clock) disable iff (rst)
    (bus.wr && bus.addr == ADDR_CNT_LO && !trigFall)
    |=> stateReg.countLow == $past(bus.wdata))
    else $error("count low write lost");
endmodule : tmr2_timer

// >>> tb/tmr2_pin_model.sv
`timescale 1ns/1ns
module tmr2_pin_model (
  input wire logic clock,
  output logic countPin,
  output logic trigPin,
  output logic t1Ovf
);
  // Pins idle high, no timer one overflow
  initial begin
    countPin = 1'b1;
    trigPin = 1'b1;
    t1Ovf = 1'b0;
  end
  // Slow pulses so the two-stage sync sees each level
  task automatic countPulses(input int n);
    repeat (n) begin
      @(posedge clock) countPin <= 1'b0;
      repeat (4) @(posedge clock);
      countPin <= 1'b1;
      repeat (4) @(posedge clock);
    end
  endtask : countPulses
  // Trigger level held long enough to be seen
  task automatic setTrig(input logic v);
    @(posedge clock) trigPin <= v;
    repeat (5) @(posedge clock);
  endtask : setTrig
  // One-cycle overflow pulse from timer one
  task automatic t1Pulse();
    @(posedge clock) t1Ovf <= 1'b1;
    @(posedge clock) t1Ovf <= 1'b0;
  endtask : t1Pulse
endmodule : tmr2_pin_model

// >>> tb/tmr2_timer_bench.sv
`timescale 1ns/1ns
module tmr2_timer_bench;
  import tmr2_pkg::*;
  logic clock, rst, busWr, busRd, rxTick, txTick, timerIrq, countPin, trigPin, t1Ovf;
  logic [7:0] busAddr, busWdata, busRdata, v;
  int errors = 0, comparisons = 0, cycles = 0, rxTicks = 0, txTicks = 0;
  tmr2_timer tmr2_timer_i (.clock(clock), .rst(rst), .busAddr(busAddr), .busWdata(busWdata),
    .busWr(busWr), .busRd(busRd), .busRdata(busRdata), .externalCountPin(countPin),
    .externalTriggerPin(trigPin), .timerOneOverflow(t1Ovf), .receiveClockTick(rxTick),
    .transmitClockTick(txTick), .timerIrq(timerIrq));
  tmr2_pin_model tmr2_pin_model_i (.clock(clock), .countPin(countPin), .trigPin(trigPin),
    .t1Ovf(t1Ovf));
  // Clock of 100 ns period
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Serial tick counters and hang guard
  always @(posedge clock) begin
    cycles++;
    if (rxTick === 1'b1) rxTicks++;
    if (txTick === 1'b1) txTicks++;
    if (cycles == 20000) begin
      errors++;
      $display("CHECK FAILED %0t timeout", $time);
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) {busWr, busAddr, busWdata} <= {1'b1, a, d};
    @(posedge clock) busWr <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock) {busRd, busAddr} <= {1'b1, a};
    @(posedge clock) busRd <= 1'b0;
    #1 d = busRdata;
  endtask : rd
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    rd(a, v);
    chk(v, exp, msg);
  endtask : rdChk
  task automatic testReset();
    rdChk(ADDR_CTRL, CTRL_RESET, "ctrl reset");
    rdChk(ADDR_MODE, MODE_RESET, "mode reset");
    wr(8'hc0, 8'h5a);
    rdChk(8'hc0, 8'h00, "unmapped");
  endtask : testReset
  task automatic testTimerRate();
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CNT_HI, 8'h00);
    wr(ADDR_CTRL, 8'h04);
    repeat (120) @(posedge clock);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CNT_LO, v);
    chk({7'h0, v >= 8'h09 && v <= 8'h0b}, 8'h01, "rate");
    repeat (40) @(posedge clock);
    rdChk(ADDR_CNT_LO, v, "stopped");
  endtask : testTimerRate
  task automatic testOverflow();
    wr(ADDR_CAP_LO, 8'h34);
    wr(ADDR_CAP_HI, 8'h12);
    wr(ADDR_CNT_LO, 8'hfe);
    wr(ADDR_CNT_HI, 8'hff);
    wr(ADDR_CTRL, 8'h06);
    tmr2_pin_model_i.countPulses(3);
    rdChk(ADDR_CNT_LO, 8'h35, "reload lo");
    rdChk(ADDR_CNT_HI, 8'h12, "reload hi");
    rdChk(ADDR_CTRL, 8'h86, "ovf flag");
    chk({7'h0, timerIrq}, 8'h01, "irq set");
    wr(ADDR_CTRL, 8'h00);
    #1;
    chk({7'h0, timerIrq}, 8'h00, "irq clr");
  endtask : testOverflow
  task automatic testCapture();
    wr(ADDR_CNT_LO, 8'h10);
    wr(ADDR_CNT_HI, 8'h00);
    wr(ADDR_CTRL, 8'h0f);
    tmr2_pin_model_i.countPulses(5);
    tmr2_pin_model_i.setTrig(1'b0);
    tmr2_pin_model_i.setTrig(1'b1);
    rdChk(ADDR_CAP_LO, 8'h15, "cap lo");
    rdChk(ADDR_CAP_HI, 8'h00, "cap hi");
    rdChk(ADDR_CNT_LO, 8'h15, "cnt kept");
    rdChk(ADDR_CTRL, 8'h4f, "ext flag");
    chk({7'h0, timerIrq}, 8'h01, "ext irq");
    wr(ADDR_CTRL, 8'h00);
  endtask : testCapture
  task automatic testUpDown();
    wr(ADDR_MODE, 8'h01);
    rdChk(ADDR_MODE, 8'h01, "mode rw");
    wr(ADDR_CAP_LO, 8'h10);
    wr(ADDR_CAP_HI, 8'h00);
    wr(ADDR_CNT_LO, 8'h12);
    wr(ADDR_CNT_HI, 8'h00);
    tmr2_pin_model_i.setTrig(1'b0);
    wr(ADDR_CTRL, 8'h06);
    tmr2_pin_model_i.countPulses(3);
    rdChk(ADDR_CNT_LO, 8'hff, "under lo");
    rdChk(ADDR_CNT_HI, 8'hff, "under hi");
    rdChk(ADDR_CTRL, 8'hc6, "toggle");
    wr(ADDR_CTRL, 8'h46);
    #1;
    chk({7'h0, timerIrq}, 8'h00, "no ext irq");
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_MODE, 8'h00);
    tmr2_pin_model_i.setTrig(1'b1);
  endtask : testUpDown
  task automatic testTrigReload();
    wr(ADDR_CAP_LO, 8'h42);
    wr(ADDR_CAP_HI, 8'h05);
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CNT_HI, 8'h00);
    wr(ADDR_CTRL, 8'h08);
    tmr2_pin_model_i.setTrig(1'b0);
    tmr2_pin_model_i.setTrig(1'b1);
    rdChk(ADDR_CNT_LO, 8'h42, "trig reload lo");
    rdChk(ADDR_CNT_HI, 8'h05, "trig reload hi");
    rdChk(ADDR_CTRL, 8'h48, "trig ext flag");
    wr(ADDR_CTRL, 8'h00);
  endtask : testTrigReload
  task automatic testSerial();
    int r0, t0;
    wr(ADDR_CAP_LO, 8'h00);
    wr(ADDR_CAP_HI, 8'h20);
    wr(ADDR_CNT_LO, 8'hff);
    wr(ADDR_CNT_HI, 8'hff);
    wr(ADDR_CTRL, 8'h27);
    r0 = rxTicks;
    t0 = txTicks;
    tmr2_pin_model_i.countPulses(1);
    chk(8'(rxTicks - r0), 8'h01, "rx tick");
    rdChk(ADDR_CNT_HI, 8'h20, "forced reload");
    rdChk(ADDR_CTRL, 8'h27, "no ovf flag");
    tmr2_pin_model_i.t1Pulse();
    @(posedge clock);
    chk(8'(txTicks - t0), 8'h01, "tx tick");
    chk(8'(rxTicks - r0), 8'h01, "rx kept");
    wr(ADDR_CAP_HI, 8'h30);
    wr(ADDR_CNT_LO, 8'hff);
    wr(ADDR_CNT_HI, 8'hff);
    wr(ADDR_CTRL, 8'h17);
    r0 = rxTicks;
    t0 = txTicks;
    tmr2_pin_model_i.countPulses(1);
    chk(8'(txTicks - t0), 8'h01, "tx wrap");
    chk(8'(rxTicks - r0), 8'h00, "rx idle");
    rdChk(ADDR_CNT_HI, 8'h30, "tx reload");
    wr(ADDR_CTRL, 8'h00);
  endtask : testSerial
  // Reset, then each scenario in turn
  initial begin
    {rst, busWr, busRd, busAddr, busWdata} = {1'b1, 18'h0};
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    testReset();
    testTimerRate();
    testOverflow();
    testCapture();
    testUpDown();
    testTrigReload();
    testSerial();
    end_of_test();
  end
endmodule : tmr2_timer_bench
